// file: design/console_port_control.sv
/*
 * Console port controller: configuration registers, control message
 * exchange with the guest driver and per-port character steering.
 * Assumes queue transport is done elsewhere and that all strobes and
 * streams are synchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module console_port_control (
	input  wire logic                           clk_sys_i,
	input  wire logic                           nrst_i,
	input  wire console_pkg::reg_req_type       reg_i,
	output logic [31:0]                         rdata_o,
	input  wire console_pkg::size_type          size_i,
	input  wire logic                           size_upd_i,
	input  wire console_pkg::cmd_type           cmd_i,
	input  wire logic                           cmd_valid_i,
	output logic                                cmd_ready_o,
	output logic                                cmd_err_o,
	input  wire console_pkg::beat_type          name_i,
	input  wire logic                           name_valid_i,
	output logic                                name_ready_o,
	output console_pkg::beat_type               ctrl_out_o,
	output logic                                ctrl_out_valid_o,
	input  wire logic                           ctrl_out_ready_i,
	input  wire console_pkg::beat_type          ctrl_in_i,
	input  wire logic                           ctrl_in_valid_i,
	output logic                                ctrl_in_ready_o,
	input  wire console_pkg::pbyte_type         char_in_i,
	input  wire logic                           char_in_valid_i,
	output logic                                char_in_ready_o,
	output console_pkg::qbyte_type              rxq_o,
	output logic                                rxq_valid_o,
	input  wire logic                           rxq_ready_i,
	input  wire console_pkg::qbyte_type         txq_i,
	input  wire logic                           txq_valid_i,
	output logic                                txq_ready_o,
	output console_pkg::pbyte_type              char_out_o,
	output logic                                char_out_valid_o,
	input  wire logic                           char_out_ready_i,
	output logic [7:0]                          urgent_byte_o,
	output logic                                urgent_valid_o,
	output logic                                cfg_change_o,
	output logic [2:0]                          features_o,
	output logic [console_pkg::NPORTS-1:0]      port_exists_o,
	output logic [console_pkg::NPORTS-1:0]      port_open_o
);
	import console_pkg::*;

	state_type          q;
	state_type          d;
	logic               be;
	logic               multi;
	logic               take;
	logic               cmd_fire;
	logic               cmd_legal;
	logic               in_legal;
	logic               out_legal;
	logic [QUEUE_W-1:0] map_rxq;
	logic [PORT_W-1:0]  map_port;
	logic               map_data;
	ctrl_msg_type       msg;
	logic               known;
	logic [PORT_W-1:0]  mport;
	logic               mport_ok;
	ctrl_msg_type       out_msg;
	logic [63:0]        out_wire;
	logic [31:0]        tail;

	// ************************************************************
	// helpers
	// ************************************************************
	queue_map u_map (
		.port_i     (char_in_i.port),
		.queue_i    (txq_i.queue),
		.rx_queue_o (map_rxq),
		.tx_port_o  (map_port),
		.tx_data_o  (map_data)
	);

	ctrl_decode u_dec (
		.raw_i   (q.rx_sh),
		.be_i    (be),
		.msg_o   (msg),
		.known_o (known)
	);

	assign be    = q.mode[MODE_LEGACY] & q.mode[MODE_BIG];
	assign multi = q.ack[FEAT_MULTI];
	assign take  = !q.out_v || ctrl_out_ready_i;

	assign mport    = msg.port[PORT_W-1:0];
	assign mport_ok = (msg.port < PORT_LIMIT) && q.exist[mport];

	// announcements are refused with cmd_err until the driver is ready so none is lost before it listens
	always_comb begin
		if (!(multi && q.drv_ready)) begin
			cmd_legal = 1'b0;
		end else if (cmd_i.op == op_add) begin
			cmd_legal = !q.exist[cmd_i.port];
		end else begin
			cmd_legal = q.exist[cmd_i.port];
		end
	end

	always_comb begin
		out_msg.port  = 32'(cmd_i.port);
		out_msg.value = 16'h0000;
		unique case (cmd_i.op)
			op_add:     out_msg.ev = EV_ADD;
			op_remove:  out_msg.ev = EV_REMOVE;
			op_console: out_msg.ev = EV_CONSOLE;
			op_resize:  out_msg.ev = EV_RESIZE;
			op_open: begin
				out_msg.ev    = EV_OPEN;
				out_msg.value = {15'h0000, cmd_i.open};
			end
			default:    out_msg.ev = EV_NAME;
		endcase
	end

	assign out_wire = {fix16(out_msg.value, be), fix16(out_msg.ev, be),
		fix32(out_msg.port, be)};
	assign tail = {fix16(q.size.rows, be), fix16(q.size.cols, be)};

	assign in_legal  = char_in_i.port == '0 ||
		(multi && q.exist[char_in_i.port]);
	assign out_legal = map_data &&
		(map_port == '0 || (multi && q.exist[map_port]));

	assign cmd_ready_o     = (q.tx_st == tx_idle) && take;
	assign cmd_fire        = cmd_valid_i && cmd_ready_o;
	assign name_ready_o    = (q.tx_st == tx_name) && take;
	assign ctrl_in_ready_o = !q.rx_full;
	assign char_in_ready_o = !q.rxq_v || rxq_ready_i;
	assign txq_ready_o     = !q.txp_v || char_out_ready_i;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d          = q;
		d.urgent_v = 1'b0;
		d.cfg_chg  = 1'b0;
		d.cmd_err  = 1'b0;
		d.rdata    = 32'h0000_0000;

		// read data stand only in the cycle after the strobe
		if (reg_i.re) begin
			unique case (reg_i.addr)
				OFS_COLS:    d.rdata = {16'h0000, fix16(q.size.cols, be)};
				OFS_ROWS:    d.rdata = {16'h0000, fix16(q.size.rows, be)};
				OFS_LIMIT:   d.rdata = fix32(PORT_LIMIT, be);
				OFS_FEAT:    d.rdata = 32'(FEAT_OFFER);
				OFS_ACK:     d.rdata = 32'(q.ack);
				OFS_MODE:    d.rdata = 32'(q.mode);
				OFS_EXIST:   d.rdata = 32'(q.exist);
				OFS_OPEN:    d.rdata = 32'(q.opened);
				OFS_PORT_OK: d.rdata = 32'(q.port_ok);
				OFS_STAT:    d.rdata = {29'h0, q.dropped, q.drv_fail,
					q.drv_ready};
				default:     d.rdata = 32'h0000_0000;
			endcase
		end

		if (reg_i.we) begin
			unique case (reg_i.addr)
				OFS_URGENT: begin
					// no gate on features or queues: must work on a dead guest
					d.urgent   = reg_i.wdata[7:0];
					d.urgent_v = 1'b1;
				end
				OFS_ACK:  d.ack  = reg_i.wdata[2:0] & FEAT_OFFER;
				OFS_MODE: d.mode = reg_i.wdata[1:0];
				OFS_STAT: begin
					// write one to clear; hardware sets below win
					d.drv_ready = q.drv_ready & ~reg_i.wdata[STAT_READY];
					d.drv_fail  = q.drv_fail & ~reg_i.wdata[STAT_FAIL];
					d.dropped   = q.dropped & ~reg_i.wdata[STAT_DROP];
				end
				default: ;
			endcase
		end

		if (size_upd_i) begin
			d.size    = size_i;
			d.cfg_chg = q.ack[FEAT_SIZE];
		end

		// ************************************************************
		// character steering
		// ************************************************************
		if (q.rxq_v && rxq_ready_i) begin
			d.rxq_v = 1'b0;
		end
		if (char_in_valid_i && char_in_ready_o) begin
			if (in_legal) begin
				d.rxq_v      = 1'b1;
				d.rxq.queue  = map_rxq;
				d.rxq.data   = char_in_i.data;
			end else begin
				d.dropped = 1'b1;
			end
		end

		if (q.txp_v && char_out_ready_i) begin
			d.txp_v = 1'b0;
		end
		if (txq_valid_i && txq_ready_o) begin
			if (out_legal) begin
				d.txp_v      = 1'b1;
				d.txp.port   = map_port;
				d.txp.data   = txq_i.data;
			end else begin
				d.dropped = 1'b1;
			end
		end

		// ************************************************************
		// control transmit queue: driver to device
		// ************************************************************
		if (ctrl_in_valid_i && ctrl_in_ready_o) begin
			// bytes past the header are ignored up to the last one
			if (q.rx_cnt < HDR_BYTES) begin
				d.rx_sh[8*q.rx_cnt +: 8] = ctrl_in_i.data;
				d.rx_cnt = q.rx_cnt + 4'h1;
			end
			if (ctrl_in_i.last) begin
				d.rx_cnt  = 4'h0;
				d.rx_full = q.rx_cnt >= HDR_BYTES - 4'h1;
			end
		end

		if (q.rx_full) begin
			d.rx_full = 1'b0;
			if (!multi || !known) begin
				d.dropped = 1'b1;
			end else begin
				unique case (msg.ev)
					EV_DRV_READY: begin
						// port number deliberately not looked at
						if (msg.value == 16'h0001) begin
							d.drv_ready = 1'b1;
						end else begin
							d.drv_fail = 1'b1;
						end
					end
					EV_PORT_READY: begin
						if (mport_ok) begin
							d.port_ok[mport] = msg.value == 16'h0001;
						end else begin
							d.dropped = 1'b1;
						end
					end
					EV_OPEN: begin
						if (mport_ok) begin
							d.opened[mport] = msg.value == 16'h0001;
						end else begin
							d.dropped = 1'b1;
						end
					end
					default: d.dropped = 1'b1;
				endcase
			end
		end

		// ************************************************************
		// control receive queue: device to driver
		// ************************************************************
		if (q.out_v && ctrl_out_ready_i) begin
			d.out_v = 1'b0;
		end

		unique case (q.tx_st)
			tx_idle: begin
				if (cmd_fire && !cmd_legal) begin
					d.cmd_err = 1'b1;
				end else if (cmd_fire) begin
					d.out.data     = out_wire[7:0];
					d.out.last     = 1'b0;
					d.out_v        = 1'b1;
					d.tx_sh        = {8'h00, tail, out_wire[63:8]};
					d.tx_left      = (cmd_i.op == op_resize) ?
						RESIZE_BYTES - 4'h1 : HDR_BYTES - 4'h1;
					d.name_after   = cmd_i.op == op_name;
					d.tx_st        = tx_hdr;
					if (cmd_i.op == op_add) begin
						d.exist[cmd_i.port]   = 1'b1;
						d.port_ok[cmd_i.port] = 1'b0;
					end
					if (cmd_i.op == op_remove) begin
						d.exist[cmd_i.port]   = 1'b0;
						d.opened[cmd_i.port]  = 1'b0;
						d.port_ok[cmd_i.port] = 1'b0;
					end
				end
			end
			tx_hdr: begin
				if (take) begin
					d.out.data = q.tx_sh[7:0];
					d.out.last = q.tx_left == 4'h1 && !q.name_after;
					d.out_v    = 1'b1;
					d.tx_sh    = {8'h00, q.tx_sh[95:8]};
					d.tx_left  = q.tx_left - 4'h1;
					if (q.tx_left == 4'h1) begin
						d.tx_st = q.name_after ? tx_name : tx_idle;
					end
				end
			end
			tx_name: begin
				// name bytes pass as given; no zero is appended
				if (name_valid_i && name_ready_o) begin
					d.out   = name_i;
					d.out_v = 1'b1;
					if (name_i.last) begin
						d.tx_st = tx_idle;
					end
				end
			end
			default: d.tx_st = tx_idle;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q           <= '0;
			q.size.cols <= COLS_RST;
			q.size.rows <= ROWS_RST;
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign rdata_o          = q.rdata;
	assign cmd_err_o        = q.cmd_err;
	assign ctrl_out_o       = q.out;
	assign ctrl_out_valid_o = q.out_v;
	assign rxq_o            = q.rxq;
	assign rxq_valid_o      = q.rxq_v;
	assign char_out_o       = q.txp;
	assign char_out_valid_o = q.txp_v;
	assign urgent_byte_o    = q.urgent;
	assign urgent_valid_o   = q.urgent_v;
	assign cfg_change_o     = q.cfg_chg;
	assign features_o       = q.ack;
	assign port_exists_o    = q.exist;
	assign port_open_o      = q.opened;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	sequence s_urgent_out;
		urgent_valid_o && urgent_byte_o == $past(reg_i.wdata[7:0]);
	endsequence

	sequence s_add_first;
		ctrl_out_valid_o && !ctrl_out_o.last &&
			ctrl_out_o.data == $past(8'(cmd_i.port));
	endsequence

	property p_urgent_byte;
		(reg_i.we && reg_i.addr == OFS_URGENT) |=> s_urgent_out;
	endproperty
	a_urgent_byte: assert property (p_urgent_byte)
		else $error("urgent byte not forwarded");

	property p_urgent_unconf;
		(reg_i.we && reg_i.addr == OFS_URGENT && q.ack == 3'h0)
			|=> urgent_valid_o;
	endproperty
	a_urgent_unconf: assert property (p_urgent_unconf)
		else $error("urgent write lost on unconfigured device");

	property p_size_chg;
		(size_upd_i && q.ack[FEAT_SIZE])
			|=> cfg_change_o && q.size == $past(size_i);
	endproperty
	a_size_chg: assert property (p_size_chg)
		else $error("size update without config change");

	property p_add_refused;
		(cmd_fire && cmd_i.op == op_add && q.exist[cmd_i.port])
			|=> cmd_err_o && !ctrl_out_valid_o ##1 q.tx_st == tx_idle;
	endproperty
	a_add_refused: assert property (p_add_refused)
		else $error("add for existing port was sent");

	property p_remove_refused;
		(cmd_fire && cmd_i.op == op_remove && !q.exist[cmd_i.port])
			|=> cmd_err_o && !ctrl_out_valid_o;
	endproperty
	a_remove_refused: assert property (p_remove_refused)
		else $error("remove for unknown port was sent");

	property p_add_hdr;
		(cmd_fire && cmd_legal && cmd_i.op == op_add && !be)
			|=> s_add_first ##0 q.tx_left == 4'h7;
	endproperty
	a_add_hdr: assert property (p_add_hdr)
		else $error("add message header malformed");

	property p_rx_map;
		(char_in_valid_i && char_in_ready_o && multi &&
			char_in_i.port != '0 && q.exist[char_in_i.port])
			|=> rxq_valid_o && rxq_o.queue == $past(q_rx(char_in_i.port));
	endproperty
	a_rx_map: assert property (p_rx_map)
		else $error("character steered to wrong receive queue");

	property p_tx_port0;
		(txq_valid_i && txq_ready_o && txq_i.queue == QUEUE_W'(1))
			|=> char_out_valid_o && char_out_o.port == '0;
	endproperty
	a_tx_port0: assert property (p_tx_port0)
		else $error("port 0 transmit queue not served");

	property p_unknown;
		(q.rx_full && !known) |=> q.opened == $past(q.opened) &&
			q.port_ok == $past(q.port_ok) && q.dropped;
	endproperty
	a_unknown: assert property (p_unknown)
		else $error("unknown event changed port state");

	property p_drv_ready;
		(q.rx_full && multi && known && msg.ev == EV_DRV_READY &&
			msg.value == 16'h0001) |=> q.drv_ready;
	endproperty
	a_drv_ready: assert property (p_drv_ready)
		else $error("driver ready not recorded");

endmodule // console_port_control

// file: design/console_pkg.sv
/*
 * Shared constants, carriers and byte-order helpers of the console port
 * controller. Assumes a single 100 MHz clock domain for all users.
 */
package console_pkg;

	localparam int NPORTS  = 8;
	localparam int PORT_W  = 3;
	localparam int QUEUE_W = 5;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_COLS    = 8'h00;
	localparam logic [7:0] OFS_ROWS    = 8'h04;
	localparam logic [7:0] OFS_LIMIT   = 8'h08;
	localparam logic [7:0] OFS_URGENT  = 8'h0c;
	localparam logic [7:0] OFS_FEAT    = 8'h10;
	localparam logic [7:0] OFS_ACK     = 8'h14;
	localparam logic [7:0] OFS_MODE    = 8'h18;
	localparam logic [7:0] OFS_EXIST   = 8'h1c;
	localparam logic [7:0] OFS_OPEN    = 8'h20;
	localparam logic [7:0] OFS_STAT    = 8'h24;
	localparam logic [7:0] OFS_PORT_OK = 8'h28;

	// ************************************************************
	// fields and reset values
	// ************************************************************
	localparam int FEAT_SIZE   = 0;
	localparam int FEAT_MULTI  = 1;
	localparam int FEAT_URGENT = 2;
	localparam logic [2:0] FEAT_OFFER = 3'h7;
	localparam int MODE_LEGACY = 0;
	localparam int MODE_BIG    = 1;
	localparam int STAT_READY  = 0;
	localparam int STAT_FAIL   = 1;
	localparam int STAT_DROP   = 2;
	localparam logic [15:0] COLS_RST   = 16'h0050;
	localparam logic [15:0] ROWS_RST   = 16'h0018;
	localparam logic [31:0] PORT_LIMIT = 32'h0000_0008;

	// ************************************************************
	// control events and message lengths
	// ************************************************************
	localparam logic [15:0] EV_DRV_READY  = 16'h0000;
	localparam logic [15:0] EV_ADD        = 16'h0001;
	localparam logic [15:0] EV_REMOVE     = 16'h0002;
	localparam logic [15:0] EV_PORT_READY = 16'h0003;
	localparam logic [15:0] EV_CONSOLE    = 16'h0004;
	localparam logic [15:0] EV_RESIZE     = 16'h0005;
	localparam logic [15:0] EV_OPEN       = 16'h0006;
	localparam logic [15:0] EV_NAME       = 16'h0007;
	localparam logic [3:0]  HDR_BYTES     = 4'h8;
	localparam logic [3:0]  RESIZE_BYTES  = 4'hc;

	typedef enum logic [2:0] {
		op_add, op_remove, op_console, op_resize, op_open, op_name
	} cmd_op_type;

	typedef enum logic [1:0] {tx_idle, tx_hdr, tx_name} tx_state_type;

	typedef struct packed {
		cmd_op_type          op;
		logic [PORT_W-1:0]   port;
		logic                open;
	} cmd_type;

	typedef struct packed {
		logic [31:0] port;
		logic [15:0] ev;
		logic [15:0] value;
	} ctrl_msg_type;

	typedef struct packed {logic [7:0] data; logic last;} beat_type;
	typedef struct packed {
		logic [QUEUE_W-1:0] queue;
		logic [7:0]         data;
	} qbyte_type;
	typedef struct packed {
		logic [PORT_W-1:0] port;
		logic [7:0]        data;
	} pbyte_type;
	typedef struct packed {logic [15:0] cols; logic [15:0] rows;} size_type;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} reg_req_type;

	typedef struct packed {
		size_type          size;
		logic [2:0]        ack;
		logic [1:0]        mode;
		logic [NPORTS-1:0] exist;
		logic [NPORTS-1:0] opened;
		logic [NPORTS-1:0] port_ok;
		logic              drv_ready;
		logic              drv_fail;
		logic              dropped;
		logic [31:0]       rdata;
		logic [7:0]        urgent;
		logic              urgent_v;
		logic              cfg_chg;
		logic              cmd_err;
		tx_state_type      tx_st;
		logic [95:0]       tx_sh;
		logic [3:0]        tx_left;
		logic              name_after;
		beat_type          out;
		logic              out_v;
		logic [63:0]       rx_sh;
		logic [3:0]        rx_cnt;
		logic              rx_full;
		qbyte_type         rxq;
		logic              rxq_v;
		pbyte_type         txp;
		logic              txp_v;
	} state_type;

	function automatic logic [15:0] fix16(logic [15:0] x, logic be);
		return be ? {x[7:0], x[15:8]} : x;
	endfunction

	function automatic logic [31:0] fix32(logic [31:0] x, logic be);
		return be ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
	endfunction

	function automatic logic [QUEUE_W-1:0] q_rx(logic [PORT_W-1:0] p);
		return (p == '0) ? '0 : QUEUE_W'({p, 1'b0}) + QUEUE_W'(2);
	endfunction

endpackage

// file: design/queue_map.sv
/*
 * Port to queue index translation, both directions.
 * Assumes queue indices wider than any legal index are simply unmapped.
 */
`timescale 1ns/1ps
module queue_map (
	input  wire logic [console_pkg::PORT_W-1:0]  port_i,
	input  wire logic [console_pkg::QUEUE_W-1:0] queue_i,
	output logic [console_pkg::QUEUE_W-1:0]      rx_queue_o,
	output logic [console_pkg::PORT_W-1:0]       tx_port_o,
	output logic                                 tx_data_o
);
	import console_pkg::*;

	logic [QUEUE_W-1:0] off;

	assign rx_queue_o = q_rx(port_i);
	assign off        = queue_i - QUEUE_W'(3);
	// queue 1 is port 0; odd queues 5 to 17 are ports 1 to 7
	assign tx_port_o  = (queue_i == QUEUE_W'(1)) ? '0 : off[PORT_W:1];
	assign tx_data_o  = (queue_i == QUEUE_W'(1)) ||
		(queue_i[0] && queue_i >= QUEUE_W'(5) &&
		off[QUEUE_W-1:PORT_W+1] == '0);
endmodule // queue_map

// file: design/ctrl_decode.sv
/*
 * Unpacks an eight-byte control message in wire order.
 * Assumes byte 0 of the message sits in raw_i[7:0].
 */
`timescale 1ns/1ps
module ctrl_decode (
	input  wire logic [63:0]        raw_i,
	input  wire logic               be_i,
	output console_pkg::ctrl_msg_type msg_o,
	output logic                    known_o
);
	import console_pkg::*;

	assign msg_o.port  = fix32(raw_i[31:0], be_i);
	assign msg_o.ev    = fix16(raw_i[47:32], be_i);
	assign msg_o.value = fix16(raw_i[63:48], be_i);
	assign known_o     = msg_o.ev <= EV_NAME;
endmodule // ctrl_decode

// file: testbench/guest_driver_model.sv
/*
 * Guest driver side of the control queues: takes device messages and
 * sends driver messages. Assumes the caller starts send after an edge.
 */
`timescale 1ns/1ps
module guest_driver_model
	import console_pkg::*;
(
	input  wire logic     clk_sys_i,
	input  wire logic     slow_i,
	input  wire beat_type out_i,
	input  wire logic     out_valid_i,
	output logic          out_ready_o,
	output beat_type      in_o,
	output logic          in_valid_o,
	input  wire logic     in_ready_i
);
	logic [7:0] got[$];
	initial begin
		out_ready_o = 1'b1;
		in_o = '0;
		in_valid_o = 1'b0;
	end
	// slow mode stalls every other cycle
	always @(posedge clk_sys_i) begin
		if (out_valid_i && out_ready_o)
			got.push_back(out_i.data);
		out_ready_o <= slow_i ? ~out_ready_o : 1'b1;
	end
	task automatic send(input logic [31:0] p, input logic [15:0] ev, vl);
		logic [63:0] m;
		m = {vl, ev, p};
		for (int i = 0; i < 8; i++) begin
			in_o <= '{m[8*i +: 8], i == 7}; // one buffer a message
			in_valid_o <= 1'b1;
			do @(posedge clk_sys_i); while (!in_ready_i);
		end
		in_valid_o <= 1'b0;
		in_o <= ~in_o; // released bus shows no stale byte
	endtask
endmodule // guest_driver_model

// file: testbench/console_port_control_tb.sv
/*
 * Self-checking bench of console_port_control.
 * Assumes the guest driver model stands on the control queues.
 */
`timescale 1ns/1ps
module console_port_control_tb;
	import console_pkg::*;
	logic        clk_sys_i = 0, nrst_i = 0, slow = 0;
	reg_req_type reg_i = '0;
	cmd_type     cmd_i = '{op_add, 3'h0, 1'b0};
	pbyte_type   char_in_i = '0;
	logic        cmd_valid_i = 0, char_in_valid_i = 0;
	logic [31:0] rdata_o;
	logic        cmd_ready_o, cmd_err_o, rxq_valid_o, urgent_valid_o;
	logic        co_v, co_r, ci_v, ci_r;
	logic [7:0]  urgent_byte_o;
	logic [7:0]  exist, opened;
	logic [2:0]  feat;
	logic        size_upd_i = 0, txq_valid_i = 0;
	logic        cfg_change_o, char_out_valid_o;
	size_type    size_i = '0;
	qbyte_type   txq_i = '0;
	pbyte_type   char_out_o;
	qbyte_type   rxq_o;
	beat_type    co, ci;
	int          err_count = 0, samples_checked = 0, cyc = 0;
	initial forever #5 clk_sys_i = ~clk_sys_i;
	console_port_control DUT (.clk_sys_i, .nrst_i, .reg_i, .rdata_o,
		.size_i, .size_upd_i, .cmd_i, .cmd_valid_i, .cmd_ready_o,
		.cmd_err_o, .name_i('0), .name_valid_i(1'b0), .name_ready_o(),
		.ctrl_out_o(co), .ctrl_out_valid_o(co_v), .ctrl_out_ready_i(co_r),
		.ctrl_in_i(ci), .ctrl_in_valid_i(ci_v), .ctrl_in_ready_o(ci_r),
		.char_in_i, .char_in_valid_i, .char_in_ready_o(), .rxq_o,
		.rxq_valid_o, .rxq_ready_i(1'b1), .txq_i, .txq_valid_i,
		.txq_ready_o(), .char_out_o, .char_out_valid_o,
		.char_out_ready_i(1'b1), .urgent_byte_o, .urgent_valid_o,
		.cfg_change_o, .features_o(feat), .port_exists_o(exist),
		.port_open_o(opened));
	guest_driver_model gm (.clk_sys_i, .slow_i(slow), .out_i(co),
		.out_valid_i(co_v), .out_ready_o(co_r), .in_o(ci),
		.in_valid_o(ci_v), .in_ready_i(ci_r));
	task automatic check(string n, logic [63:0] s, e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys_i);
		reg_i <= '0;
	endtask
	task automatic rd(string n, logic [7:0] a, logic [31:0] e);
		reg_i <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys_i);
		reg_i <= '0;
		#1 check(n, rdata_o, e);
		@(posedge clk_sys_i);
	endtask
	task automatic t_regs();
		rd("features", OFS_FEAT, 32'h7);
		rd("limit", OFS_LIMIT, PORT_LIMIT);
		rd("columns", OFS_COLS, 32'h50);
		rd("unmapped", 8'h3c, 32'h0);
		$display("regs done");
	endtask
	task automatic t_urgent();
		wr(OFS_URGENT, 32'h1234_56a5);
		#1 check("urgent", {urgent_valid_o, urgent_byte_o}, 9'h1a5);
		@(posedge clk_sys_i);
		$display("urgent done");
	endtask
	task automatic cmd(cmd_op_type o, logic [2:0] p, logic [31:0] err);
		cmd_i <= '{o, p, 1'b0};
		cmd_valid_i <= 1'b1;
		do @(posedge clk_sys_i); while (!cmd_ready_o);
		cmd_valid_i <= 1'b0;
		#1 check("refused", cmd_err_o, err);
		@(posedge clk_sys_i);
	endtask
	task automatic t_ports();
		wr(OFS_ACK, 32'h7);
		gm.send(32'h5, EV_DRV_READY, 16'h1);
		repeat (3) @(posedge clk_sys_i);
		check("acked", feat, 32'h7);
		rd("ready", OFS_STAT, 32'h1);
		slow <= 1'b1;
		cmd(op_add, 3'h2, 32'h0);
		repeat (30) @(posedge clk_sys_i);
		check("add", {>>{gm.got}}, 64'h0200_0000_0100_0000);
		check("exist", exist, 8'h04);
		cmd(op_add, 3'h2, 32'h1);
		gm.send(32'h2, 16'h0009, 16'h1);
		repeat (3) @(posedge clk_sys_i);
		rd("drop", OFS_STAT, 32'h5);
		check("kept", exist, 8'h04);
		gm.got.delete();
		cmd(op_console, 3'h2, 32'h0);
		repeat (30) @(posedge clk_sys_i);
		check("console", {>>{gm.got}}, 64'h0200_0000_0400_0000);
		gm.send(32'h2, EV_OPEN, 16'h1);
		@(posedge clk_sys_i);
		gm.send(32'h2, EV_PORT_READY, 16'h1);
		repeat (3) @(posedge clk_sys_i);
		check("open", opened, 8'h04);
		rd("port ok", OFS_PORT_OK, 32'h4);
		$display("ports done");
	endtask
	task automatic t_size();
		size_i <= '{16'h0084, 16'h0032};
		size_upd_i <= 1'b1;
		@(posedge clk_sys_i);
		size_upd_i <= 1'b0;
		#1 check("change", cfg_change_o, 32'h1);
		@(posedge clk_sys_i);
		rd("rows", OFS_ROWS, 32'h32);
		wr(OFS_MODE, 32'h3);
		@(posedge clk_sys_i);
		rd("legacy", OFS_LIMIT, 32'h0800_0000);
		wr(OFS_MODE, 32'h0);
		$display("size done");
	endtask
	task automatic t_tx(logic [4:0] qi, logic [11:0] e);
		// only transmit queues carry device-readable buffers
		txq_i <= '{qi, 8'h42};
		txq_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		txq_valid_i <= 1'b0;
		#1 check("txport", {char_out_valid_o, char_out_o}, e);
		@(posedge clk_sys_i);
		$display("tx done");
	endtask
	task automatic t_char(logic [2:0] p, logic [4:0] q);
		char_in_i <= '{p, 8'h41};
		char_in_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		char_in_valid_i <= 1'b0;
		#1 check("queue", {rxq_valid_o, rxq_o}, {1'b1, q, 8'h41});
		@(posedge clk_sys_i);
		$display("char done");
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// a run past this ceiling is a hang
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		@(posedge clk_sys_i);
		t_urgent();
		t_regs();
		t_ports();
		t_char(3'h2, 5'h6);
		t_char(3'h0, 5'h0);
		t_size();
		t_tx(5'h7, {1'b1, 3'h2, 8'h42});
		t_tx(5'h1, {1'b1, 3'h0, 8'h42});
		cmd(op_remove, 3'h2, 32'h0);
		check("removed", exist, 8'h00);
		print_verdict();
	end
endmodule // console_port_control_tb
